// ==== rtl/ferh_recorder.sv ====
// Purpose: Keeps the last five fault records of the voltage protection stages
// Assumes: Stage start, trip, blocked and operate-time inputs are synchronous
// Notes: Non-volatility is a property of the storage macro; master reset clears it
`timescale 1ns/1ps
module ferh_recorder #(
    parameter int NREC = ferh_pkg::NUM_RECORDS,
    parameter int NSTG = ferh_pkg::NUM_STAGES
) (
    input wire logic sys_clk, // System clock
    input wire logic rst, // Asynchronous reset
    input wire logic master_reset, // Clears all records and counts
    input wire logic [ferh_pkg::VOLT_W-1:0] volt_max_meas, // Highest main voltage
    input wire logic [ferh_pkg::VOLT_W-1:0] volt_min_meas, // Lowest main voltage
    input wire logic [ferh_pkg::VOLT_W-1:0] volt_pos_seq, // Positive-sequence voltage
    input wire logic [NSTG-1:0] stage_start, // Stage start levels
    input wire logic [NSTG-1:0] stage_trip, // Stage trip levels
    input wire logic [NSTG-1:0] stage_blocked, // Stage blocked levels
    input wire logic [NSTG-1:0] inverse_time_characteristic, // Stage uses inverse time
    input wire logic [NSTG*ferh_pkg::CLK_W-1:0] set_operate_cycles, // Set operate times
    input wire logic [NSTG*ferh_pkg::CLK_W-1:0] calc_operate_cycles, // Inverse-time operate
    input wire logic [ferh_pkg::DATE_W-1:0] rtc_date, // Date yy-mm-dd packed BCD
    input wire logic [ferh_pkg::TIME_W+8-1:0] rtc_time, // Time HHMM SS.sss packed
    input wire logic recorder_trigger, // Disturbance recorder triggered pulse
    input wire logic recorder_event_mask, // High lets the trigger code out
    input wire logic unload_enable_param, // Upload allowed when set
    input wire logic upload_req, // Upload request pulse
    input wire logic [2:0] rd_sel, // Record slot to show, 0 newest
    output logic [ferh_pkg::VOLT_W-1:0] rd_volt_extreme, // Peak or minimum voltage
    output logic [ferh_pkg::VOLT_W-1:0] rd_volt_trip, // Voltage at trip
    output logic [ferh_pkg::VOLT_W-1:0] rd_volt_pos_min, // Lowest positive sequence
    output logic [NSTG*ferh_pkg::PCT_W-1:0] rd_pct, // Start durations in percent
    output logic [ferh_pkg::DATE_W-1:0] rd_date, // Drop-off date
    output logic [ferh_pkg::TIME_W+8-1:0] rd_time, // Drop-off time
    output logic [NSTG*ferh_pkg::CNT_W-1:0] start_count, // Start counters
    output logic [2:0] record_count, // Valid records held
    output logic event_valid, // Event code strobe, one cycle
    output logic [7:0] event_code, // Event code
    output logic upload_grant, // Upload accepted, one cycle
    output logic upload_refused // Upload refused, one cycle
);
    // ******************************************
    // Types and storage
    // ******************************************
    typedef struct packed {
        logic [ferh_pkg::VOLT_W-1:0] vext;
        logic [ferh_pkg::VOLT_W-1:0] vtrip;
        logic [ferh_pkg::VOLT_W-1:0] vpos;
        logic [NSTG*ferh_pkg::PCT_W-1:0] pct;
        logic [ferh_pkg::DATE_W-1:0] date;
        logic [ferh_pkg::TIME_W+8-1:0] tod;
    } ferh_rec_t;

    typedef enum logic [1:0] {
        FERH_IDLE = 2'b00,
        FERH_ACTIVE = 2'b01,
        FERH_STORE = 2'b10
    } ferh_state_t;

    ferh_rec_t recs [NREC], next_recs [NREC];
    ferh_rec_t cur, next_cur;
    ferh_state_t state, next_state;
    logic over_seen, next_over_seen;
    logic [ferh_pkg::CLK_W-1:0] elapsed [NSTG], next_elapsed [NSTG];
    logic [ferh_pkg::CNT_W-1:0] cnt [NSTG], next_cnt [NSTG];
    logic [NSTG-1:0] start_d;
    logic [2:0] nrec, next_nrec;
    logic [ferh_pkg::PCT_W-1:0] pct_now [NSTG];
    logic any_start;

    // ******************************************
    // Per-stage timing and counting
    // ******************************************
    for (genvar s = 0; s < NSTG; s++) begin : g_stage
        logic [ferh_pkg::CLK_W-1:0] op;
        logic [ferh_pkg::CLK_W+7-1:0] scaled;
        always_comb begin
            op = inverse_time_characteristic[s] ?
                calc_operate_cycles[s*ferh_pkg::CLK_W +: ferh_pkg::CLK_W] :
                set_operate_cycles[s*ferh_pkg::CLK_W +: ferh_pkg::CLK_W];
            scaled = {elapsed[s], 7'h00} - {2'h0, elapsed[s], 5'h00} + {5'h0, elapsed[s], 2'h0};
            // Percent truncated; elapsed*100 built from shifts to avoid a multiplier
            if (stage_trip[s]) begin
                pct_now[s] = ferh_pkg::PCT_TRIP;
            end else if (stage_blocked[s] && elapsed[s] >= op) begin
                pct_now[s] = ferh_pkg::PCT_BLOCKED;
            end else if (op == '0 || elapsed[s] >= op) begin
                pct_now[s] = ferh_pkg::PCT_BLOCKED; // Trip still pending, never 100 early
            end else if (scaled / op > 7'd99) begin
                pct_now[s] = ferh_pkg::PCT_BLOCKED;
            end else begin
                pct_now[s] = ferh_pkg::PCT_W'(scaled / op);
            end
            if (stage_start[s] && pct_now[s] == '0) begin
                pct_now[s] = 7'h01; // Started stage never reads as zero
            end
            next_elapsed[s] = elapsed[s];
            if (stage_start[s] && !start_d[s]) begin
                next_elapsed[s] = ferh_pkg::CLK_W'(1);
            end else if (stage_start[s] && elapsed[s] != '1) begin
                next_elapsed[s] = elapsed[s] + 1'b1;
            end
            next_cnt[s] = cnt[s];
            if (master_reset) begin
                next_cnt[s] = '0;
            end else if (stage_start[s] && !start_d[s] && cnt[s] != ferh_pkg::START_CNT_MAX) begin
                next_cnt[s] = cnt[s] + 1'b1;
            end
        end
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                elapsed[s] <= '0;
                cnt[s] <= '0;
            end else begin
                elapsed[s] <= next_elapsed[s];
                cnt[s] <= next_cnt[s];
            end
        end
        assign start_count[s*ferh_pkg::CNT_W +: ferh_pkg::CNT_W] = cnt[s];
        a_cnt_ceiling: assert property (@(posedge sys_clk) disable iff (rst)
            cnt[s] == ferh_pkg::START_CNT_MAX && !master_reset
            |=> cnt[s] == ferh_pkg::START_CNT_MAX)
            else $error("start count left its ceiling");
        a_cnt_step: assert property (@(posedge sys_clk) disable iff (rst)
            stage_start[s] && !start_d[s] && !master_reset && cnt[s] < ferh_pkg::START_CNT_MAX
            |=> cnt[s] == $past(cnt[s]) + 1'b1)
            else $error("start count did not advance");
    end

    assign any_start = |stage_start;

    // ******************************************
    // Fault capture and history shift
    // ******************************************
    always_comb begin
        next_state = state;
        next_cur = cur;
        next_over_seen = over_seen;
        next_nrec = nrec;
        next_recs = recs;
        case (state)
            FERH_IDLE: begin
                if (any_start) begin
                    next_state = FERH_ACTIVE;
                    next_cur = '0;
                    next_cur.vpos = ferh_pkg::VOLT_MIN_RESET;
                    next_over_seen = |stage_start[ferh_pkg::FIRST_UNDER_STAGE-1:0];
                    next_cur.vext = next_over_seen ? ferh_pkg::VOLT_ZERO : ferh_pkg::VOLT_MIN_RESET;
                end
            end
            FERH_ACTIVE: begin
                if (|stage_start[ferh_pkg::FIRST_UNDER_STAGE-1:0]) begin
                    next_over_seen = 1'b1;
                end
                if (over_seen) begin
                    if (volt_max_meas > cur.vext) begin
                        next_cur.vext = volt_max_meas;
                    end
                end else begin
                    if (volt_min_meas < cur.vext) begin
                        next_cur.vext = volt_min_meas;
                    end
                    if (volt_pos_seq < cur.vpos) begin
                        next_cur.vpos = volt_pos_seq;
                    end
                end
                for (int s = 0; s < NSTG; s++) begin
                    if (stage_start[s]) begin
                        next_cur.pct[s*ferh_pkg::PCT_W +: ferh_pkg::PCT_W] = pct_now[s];
                    end
                end
                if (|stage_trip && cur.vtrip == '0) begin
                    next_cur.vtrip = over_seen ? volt_max_meas : volt_min_meas;
                end
                if (!any_start) begin
                    next_cur.date = rtc_date;
                    next_cur.tod = rtc_time;
                    if (over_seen || next_cur.vpos == ferh_pkg::VOLT_MIN_RESET) begin
                        next_cur.vpos = ferh_pkg::VOLT_ZERO;
                    end
                    next_state = FERH_STORE;
                end
            end
            FERH_STORE: begin
                next_recs[0] = cur;
                for (int i = 1; i < NREC; i++) begin
                    next_recs[i] = recs[i-1];
                end
                if (nrec < 3'(NREC)) begin
                    next_nrec = nrec + 1'b1;
                end
                next_state = FERH_IDLE;
            end
            default: next_state = FERH_IDLE;
        endcase
        if (master_reset) begin
            next_recs = '{default: '0};
            next_nrec = '0;
            next_state = FERH_IDLE;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= FERH_IDLE;
            cur <= '0;
            over_seen <= 1'b0;
            nrec <= '0;
            start_d <= '0;
            recs <= '{default: '0};
        end else begin
            state <= next_state;
            cur <= next_cur;
            over_seen <= next_over_seen;
            nrec <= next_nrec;
            start_d <= stage_start;
            recs <= next_recs;
        end
    end

    a_shift_order: assert property (@(posedge sys_clk) disable iff (rst)
        state == FERH_STORE && !master_reset |=> recs[1] == $past(recs[0]))
        else $error("history did not shift");
    a_newest_store: assert property (@(posedge sys_clk) disable iff (rst)
        state == FERH_STORE && !master_reset |=> recs[0] == $past(cur))
        else $error("newest record not stored");
    a_master_clear: assert property (@(posedge sys_clk) disable iff (rst)
        master_reset |=> nrec == '0 && recs[0] == '0)
        else $error("master reset left records");
    a_trip_pct: assert property (@(posedge sys_clk) disable iff (rst)
        state == FERH_ACTIVE && stage_trip[0] && stage_start[0] && !master_reset
        |=> cur.pct[ferh_pkg::PCT_W-1:0] == ferh_pkg::PCT_TRIP)
        else $error("trip percent not 100");
    a_stamp_dropoff: assert property (@(posedge sys_clk) disable iff (rst)
        state == FERH_ACTIVE && !any_start && !master_reset
        |=> state == FERH_STORE && cur.date == $past(rtc_date))
        else $error("time stamp not taken at drop-off");

    // ******************************************
    // Read-out, recorder event and upload gate
    // ******************************************
    logic next_event_valid, next_grant, next_refused;
    ferh_rec_t rd_rec;
    always_comb begin
        next_event_valid = recorder_trigger && recorder_event_mask;
        next_grant = upload_req && unload_enable_param;
        next_refused = upload_req && !unload_enable_param;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            event_valid <= 1'b0;
            event_code <= 8'h00;
            upload_grant <= 1'b0;
            upload_refused <= 1'b0;
            rd_rec <= '0;
        end else begin
            event_valid <= next_event_valid;
            event_code <= next_event_valid ? ferh_pkg::TRIGGER_EVENT_CODE : 8'h00;
            upload_grant <= next_grant;
            upload_refused <= next_refused;
            rd_rec <= (rd_sel < 3'(NREC)) ? recs[rd_sel] : '0;
        end
    end

    assign rd_volt_extreme = rd_rec.vext;
    assign rd_volt_trip = rd_rec.vtrip;
    assign rd_volt_pos_min = rd_rec.vpos;
    assign rd_pct = rd_rec.pct;
    assign rd_date = rd_rec.date;
    assign rd_time = rd_rec.tod;
    assign record_count = nrec;

    a_upload_gate: assert property (@(posedge sys_clk) disable iff (rst)
        upload_req && !unload_enable_param |=> upload_refused && !upload_grant)
        else $error("upload not refused");
    a_event_code: assert property (@(posedge sys_clk) disable iff (rst)
        recorder_trigger && recorder_event_mask
        |=> event_valid && event_code == ferh_pkg::TRIGGER_EVENT_CODE)
        else $error("trigger event code missing");
endmodule

// ==== pkg/ferh_pkg.sv ====
// Purpose: Shared constants for the fault event history recorder
// Assumes: Voltages arrive as unsigned multiples of rated voltage in fixed point
// Notes: Percent figures are integer percent of the operate time
package ferh_pkg;
    localparam int NUM_RECORDS = 5;
    localparam int NUM_STAGES = 4;
    localparam int VOLT_W = 16;
    localparam int TIME_W = 24;
    localparam int DATE_W = 24;
    localparam int CLK_W = 32;
    localparam int PCT_W = 7;
    localparam int CNT_W = 10;
    localparam logic [PCT_W-1:0] PCT_TRIP = 7'h64;
    localparam logic [PCT_W-1:0] PCT_BLOCKED = 7'h63;
    localparam logic [CNT_W-1:0] START_CNT_MAX = 10'h3E7;
    localparam logic [VOLT_W-1:0] VOLT_MIN_RESET = 16'hFFFF;
    localparam logic [VOLT_W-1:0] VOLT_ZERO = 16'h0000;
    localparam logic [7:0] TRIGGER_EVENT_CODE = 8'h1F;
    // Stage order: 0 high over, 1 low over, 2 high under, 3 low under
    localparam int FIRST_UNDER_STAGE = 2;
endpackage

// ==== tb/ferh_recorder_tb.sv ====
// Purpose: Self-checking bench for the fault event history recorder
// Assumes: Inputs change at the falling edge; store settles within a few cycles of drop-off
// Notes: Percent figures of untripped starts short of their operate time are checked within a four-value window
`timescale 1ns/1ps
module ferh_recorder_tb;
    logic sys_clk, rst, master_reset, recorder_trigger, recorder_event_mask;
    logic unload_enable_param, upload_req, event_valid, upload_grant, upload_refused;
    logic [15:0] volt_max_meas, volt_min_meas, volt_pos_seq;
    logic [15:0] rd_volt_extreme, rd_volt_trip, rd_volt_pos_min;
    logic [3:0] stage_start, stage_trip, stage_blocked, inverse_time_characteristic;
    logic [127:0] set_operate_cycles, calc_operate_cycles;
    logic [23:0] rtc_date, rd_date;
    logic [31:0] rtc_time, rd_time;
    logic [2:0] rd_sel, record_count;
    logic [27:0] rd_pct;
    logic [39:0] start_count;
    logic [7:0] event_code;
    int n_mismatch, samples_checked, i;

    ferh_recorder i_ferh_recorder (
        .sys_clk(sys_clk), .rst(rst), .master_reset(master_reset),
        .volt_max_meas(volt_max_meas), .volt_min_meas(volt_min_meas),
        .volt_pos_seq(volt_pos_seq), .stage_start(stage_start), .stage_trip(stage_trip),
        .stage_blocked(stage_blocked),
        .inverse_time_characteristic(inverse_time_characteristic),
        .set_operate_cycles(set_operate_cycles), .calc_operate_cycles(calc_operate_cycles),
        .rtc_date(rtc_date), .rtc_time(rtc_time), .recorder_trigger(recorder_trigger),
        .recorder_event_mask(recorder_event_mask),
        .unload_enable_param(unload_enable_param), .upload_req(upload_req),
        .rd_sel(rd_sel), .rd_volt_extreme(rd_volt_extreme), .rd_volt_trip(rd_volt_trip),
        .rd_volt_pos_min(rd_volt_pos_min), .rd_pct(rd_pct), .rd_date(rd_date),
        .rd_time(rd_time), .start_count(start_count), .record_count(record_count),
        .event_valid(event_valid), .event_code(event_code),
        .upload_grant(upload_grant), .upload_refused(upload_refused)
    );

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // One fault: extreme value at the middle cycle, clock value counts up each cycle
    task automatic fault(input logic [3:0] st, input logic [3:0] blk, input int len,
                         input int trip_at, input logic [15:0] v);
        logic [2:0] old;
        int k;
        old = record_count;
        stage_blocked = blk;
        for (k = 0; k < len; k++) begin
            volt_max_meas = (k == len / 2) ? v : v - 16'h0100;
            volt_min_meas = (k == len / 2) ? v : v + 16'h0100;
            volt_pos_seq = (k == len / 2) ? v : v + 16'h0200;
            rtc_time = 32'h10300000 + k;
            stage_start = st;
            stage_trip = (k >= trip_at) ? st : 4'h0;
            cyc(1);
        end
        stage_start = 4'h0;
        stage_trip = 4'h0;
        stage_blocked = 4'h0;
        for (k = 0; k < 8 && record_count == old && old != 3'h5; k++) begin
            cyc(1);
        end
        if (k == 8) begin
            chk(record_count, old + 3'h1);
            wrap_up();
        end
        rd_sel = 3'h0;
        cyc(3);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_over_trip();
        set_operate_cycles[31:0] = 32'd20;
        fault(4'h1, 4'h0, 30, 12, 16'h1400);
        chk(rd_volt_extreme, 16'h1400);
        chk(rd_volt_trip, 16'h1300);
        chk(rd_volt_pos_min, 16'h0000);
        chk(rd_pct[6:0], 7'h64);
        chk(rd_pct[27:7], 21'h000000);
        chk(rd_date, 24'h240517);
        chk(rd_time, 32'h1030001D);
        chk(record_count, 3'h1);
        $display("Test over_trip finished");
    endtask

    task automatic t_over_reset();
        set_operate_cycles[31:0] = 32'd100;
        fault(4'h1, 4'h0, 40, 999, 16'h1500);
        chk(rd_pct[6:0] inside {[38:41]}, 1'b1);
        chk(rd_volt_extreme, 16'h1500);
        chk(rd_volt_trip, 16'h0000);
        set_operate_cycles[31:0] = 32'd20;
        fault(4'h1, 4'h1, 30, 999, 16'h1500);
        chk(rd_pct[6:0], 7'h63);
        $display("Test over_reset finished");
    endtask

    task automatic t_inverse();
        inverse_time_characteristic = 4'h2;
        set_operate_cycles[63:32] = 32'd1000;
        calc_operate_cycles[63:32] = 32'd80;
        fault(4'h2, 4'h0, 40, 999, 16'h1200);
        chk(rd_pct[13:7] inside {[48:51]}, 1'b1);
        inverse_time_characteristic = 4'h0;
        $display("Test inverse finished");
    endtask

    task automatic t_under();
        fault(4'h4, 4'h0, 20, 5, 16'h0C00);
        chk(rd_volt_extreme, 16'h0C00);
        chk(rd_volt_trip, 16'h0D00);
        chk(rd_volt_pos_min, 16'h0C00);
        chk(rd_pct[20:14], 7'h64);
        $display("Test under finished");
    endtask

    task automatic t_shift();
        for (i = 0; i < 6; i++) begin
            fault(4'h1, 4'h0, 4, 999, 16'h1000 + i[15:0]);
        end
        chk(record_count, 3'h5);
        for (i = 0; i < 6; i++) begin
            rd_sel = i[2:0];
            cyc(2);
            chk(rd_volt_extreme, (i == 5) ? 16'h0000 : 16'h1005 - i[15:0]);
        end
        $display("Test shift finished");
    endtask

    task automatic t_counts();
        rd_sel = 3'h0;
        master_reset = 1'b1;
        cyc(1);
        master_reset = 1'b0;
        cyc(2);
        chk(record_count, 3'h0);
        chk(start_count[31:0], 32'h00000000);
        chk(rd_volt_extreme, 16'h0000);
        for (i = 0; i < 998; i++) begin
            fault(4'h8, 4'h0, 1, 999, 16'h0800);
        end
        chk(start_count[39:30], 10'h3E6);
        chk(start_count[29:0], 30'h00000000);
        fault(4'h8, 4'h0, 1, 999, 16'h0800);
        fault(4'h8, 4'h0, 1, 999, 16'h0800);
        chk(start_count[39:30], 10'h3E7);
        $display("Test counts finished");
    endtask

    task automatic t_event_upload();
        recorder_event_mask = 1'b1;
        recorder_trigger = 1'b1;
        cyc(1);
        recorder_trigger = 1'b0;
        chk({event_valid, event_code}, 9'h11F);
        cyc(1);
        chk(event_valid, 1'b0);
        recorder_event_mask = 1'b0;
        recorder_trigger = 1'b1;
        cyc(1);
        recorder_trigger = 1'b0;
        chk(event_valid, 1'b0);
        upload_req = 1'b1;
        cyc(1);
        chk({upload_grant, upload_refused}, 2'h1);
        unload_enable_param = 1'b1;
        cyc(1);
        upload_req = 1'b0;
        chk({upload_grant, upload_refused}, 2'h2);
        $display("Test event_upload finished");
    endtask

    // ****************************************
    // Clock and main sequence
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        n_mismatch = 0;
        samples_checked = 0;
        {master_reset, recorder_trigger, recorder_event_mask} = 3'h0;
        {unload_enable_param, upload_req, rd_sel} = 5'h00;
        {volt_max_meas, volt_min_meas, volt_pos_seq} = 48'h0;
        {stage_start, stage_trip, stage_blocked, inverse_time_characteristic} = 16'h0;
        set_operate_cycles = {4{32'd100}};
        calc_operate_cycles = {4{32'd100}};
        rtc_date = 24'h240517;
        rtc_time = 32'h00000000;
        rst = 1'b1;
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        cyc(1);
        chk(record_count, 3'h0);
        chk(start_count[39:32], 8'h00);
        chk(start_count[31:0], 32'h00000000);
        t_over_trip();
        t_over_reset();
        t_inverse();
        t_under();
        t_shift();
        t_event_upload();
        t_counts();
        wrap_up();
    end
endmodule
